// ---- timer_pkg.sv ----
// Package with register offsets, field positions, encodings and reset values of the timer.
package timer_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	// Register offsets on the plain register port.
	localparam logic [2:0] OFS_MODE = 3'h0;
	localparam logic [2:0] OFS_CCC = 3'h1;
	localparam logic [2:0] OFS_PERIOD = 3'h2;
	localparam logic [2:0] OFS_DUTY = 3'h3;
	localparam logic [2:0] OFS_COUNT = 3'h4;
	localparam logic [2:0] OFS_PRESC = 3'h5;
	localparam logic [2:0] OFS_OUTCTL = 3'h6;
	localparam logic [2:0] OFS_STATUS = 3'h7;
	// Field positions.
	localparam int CCC_PERIOD_CAP = 0;
	localparam int CCC_DUTY_CAP = 1;
	localparam int CCC_PERIOD_INV_A = 2;
	localparam int PRESC_CLK_LSB = 0;
	localparam int PRESC_EDGE_A_LSB = 4;
	localparam int PRESC_EDGE_B_LSB = 6;
	localparam int OUT_ENABLE = 0;
	localparam int OUT_PERIOD_INV = 1;
	localparam int OUT_DUTY_INV = 2;
	localparam int STAT_OVERFLOW = 0;
	// Reset values.
	localparam logic [15:0] RESET_ZERO = 16'h0000;
	localparam logic [7:0] PRESC_RESET = 8'h00;
	// Counter limit and prescaler taps.
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] DIV4_TAP = 8'h03;
	localparam logic [7:0] DIV256_TAP = 8'hFF;
	localparam logic [7:0] DIV4_MASK = 8'h03;
	// Operating modes of the counter.
	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_FREE_RUN,
		MODE_CLEAR_MATCH,
		MODE_CLEAR_EDGE_A
	} mode_t;
	// Count clock sources.
	typedef enum logic [1:0] {
		CLK_SYS,
		CLK_DIV4,
		CLK_DIV256,
		CLK_EDGE_A
	} clk_sel_t;
	// Input edge selections.
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ---- interval_ppg_pulse_timer.sv ----
// Sixteen-bit timer with interval, pulse generator and pulse width capture modes.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: Interval mode clears counter on period match, keeps counting, raises period request.
// R02: Count clock comes from the two-bit select field in prescaler bits 1:0.
// R03: Period request interval is compare value plus one count clocks.
// R04: In clear-on-match mode overflow sets only when the period value is FFFFH.
// R05: Software leaves the period register alone while interval or pulse mode runs.
// R06: Interval setup order: capture control, period, prescaler, then mode start.
// R07: Pulse mode drives a rectangular wave; period sets cycle, duty sets width.
// R08: Software keeps duty value strictly below the period value.
// R09: Pulse period is period plus one; duty ratio is duty plus one over that.
// R10: Pulse setup order: control, period, duty, output control, prescaler, mode.
// R11: Duty change while running follows the disable, write, wait, re-enable sequence.
// R12: Capture inputs sampled at the count clock; valid level needed twice in succession. The code samples every cycle when input A is the clock.
// R13: Width measured by free-running counter or by restarting on input A edges.
// R14: Free-running: input A edge copies counter into duty register, raises duty request.
// R15: Single-register measurement uses both edges on input A.
// R16: Input B edge copies counter into period register and raises period request.
// R17: Dual measurement uses both edges on both inputs set as inputs.
// R18: Software reads capture, checks overflow, computes width, clears overflow.
// R19: Measurement setup order: capture control, prescaler, then mode start.
// R20: Edge field: 00 falling, 01 rising, 10 prohibited, 11 both edges.
// R21: Clock field: 00 system, 01 divide by 4, 10 divide by 256, 11 input A edge.
// R22: Output toggles on duty match or period match only when its enable is set.
// R23: Output enable low holds the pin at 0; high makes it follow the flip-flop.
// R24: Free-running counter wraps FFFFH to 0000H and sets overflow on the wrap.
// R25: Pulse mode toggles on both matches, giving width of duty plus one.
module interval_ppg_pulse_timer
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [timer_pkg::ADDR_W-1:0] addr,
	input wire logic [timer_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [timer_pkg::DATA_W-1:0] rdata_q,
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	output logic timer_output_pin,
	output logic period_match_irq,
	output logic duty_capture_irq
);
	import timer_pkg::*;

	// Two-flop synchronisers, noise filters and edge detection for both inputs.
	logic [1:0] pin_in;
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] hist_q;
	logic [1:0] hist_d;
	logic [1:0] filt_q;
	logic [1:0] filt_d;
	logic [1:0] prev_q;
	logic [1:0] rise;
	logic [1:0] fall;
	logic sample;

	// Control and data state.
	mode_t mode_q;
	mode_t mode_d;
	logic [2:0] ccc_q;
	logic [2:0] ccc_d;
	logic [7:0] presc_q;
	logic [7:0] presc_d;
	logic [2:0] outctl_q;
	logic [2:0] outctl_d;
	logic [15:0] period_q;
	logic [15:0] period_d;
	logic [15:0] duty_q;
	logic [15:0] duty_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic ovf_q;
	logic ovf_d;
	logic ff_q;
	logic ff_d;
	logic pin_d;
	logic pirq_d;
	logic dirq_d;
	logic [15:0] rdata_d;

	// Decoded helpers.
	logic running;
	logic tick;
	logic edge_a;
	logic edge_b;
	logic inv_edge_a;
	logic period_hit;
	logic duty_hit;
	clk_sel_t clk_sel;

	assign pin_in = {timer_input_b, timer_input_a};
	assign clk_sel = clk_sel_t'(presc_q[PRESC_CLK_LSB +: 2]);
	assign running = (mode_q != MODE_STOP);

	// Inputs are sampled at the count clock, or every cycle when input A is the clock.
	assign sample = (clk_sel == CLK_EDGE_A) ? 1'b1 : tick; // R12

	// Picks the edge requested by a two-bit edge field; the prohibited code yields none.
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		if (sel == EDGE_FALL) begin
			hit = f; // R20
		end else if (sel == EDGE_RISE) begin
			hit = r; // R20
		end else if (sel == EDGE_BOTH) begin
			hit = r | f; // R20
		end
		return hit;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			// The filtered level moves only after two equal samples in a row.
			always_comb begin
				hist_d[gi] = hist_q[gi];
				filt_d[gi] = filt_q[gi];
				if (sample) begin
					hist_d[gi] = sync_q[gi];
					if (hist_q[gi] == sync_q[gi]) begin
						filt_d[gi] = sync_q[gi]; // R12
					end
				end
			end

			// Synchroniser and filter registers.
			always_ff @(posedge clk) begin
				if (!resetn) begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
					hist_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end else begin
					meta_q[gi] <= pin_in[gi];
					sync_q[gi] <= meta_q[gi];
					hist_q[gi] <= hist_d[gi];
					filt_q[gi] <= filt_d[gi];
					prev_q[gi] <= filt_q[gi];
				end
			end

			assign rise[gi] = filt_q[gi] & ~prev_q[gi];
			assign fall[gi] = ~filt_q[gi] & prev_q[gi];
		end
	endgenerate

	assign edge_a = edge_hit(presc_q[PRESC_EDGE_A_LSB +: 2], rise[0], fall[0]);
	assign edge_b = edge_hit(presc_q[PRESC_EDGE_B_LSB +: 2], rise[1], fall[1]);
	// The edge opposite to the capture edge of input A, for the second capture register.
	assign inv_edge_a = (rise[0] | fall[0]) & ~edge_a;

	// Count clock strobe from the prescaler or the valid edge of input A.
	always_comb begin
		tick = 1'b0;
		case (clk_sel)
			CLK_SYS: tick = 1'b1; // R21
			CLK_DIV4: tick = ((div_q & DIV4_MASK) == DIV4_TAP); // R21
			CLK_DIV256: tick = (div_q == DIV256_TAP); // R21
			CLK_EDGE_A: tick = edge_a; // R21
			default: tick = 1'b0;
		endcase
		tick = tick & running; // R02
	end

	assign period_hit = (count_q == period_q);
	assign duty_hit = (count_q == duty_q);

	// Next state of the counter, compare registers, output flip-flop and register port.
	always_comb begin
		mode_d = mode_q;
		ccc_d = ccc_q;
		presc_d = presc_q;
		outctl_d = outctl_q;
		period_d = period_q;
		duty_d = duty_q;
		count_d = count_q;
		ovf_d = ovf_q;
		ff_d = ff_q;
		pirq_d = 1'b0;
		dirq_d = 1'b0;
		rdata_d = RESET_ZERO;
		div_d = running ? div_q + 8'h01 : PRESC_RESET;

		// Software writes; hardware events below take priority over them.
		if (wr) begin
			if (addr == OFS_MODE) begin
				mode_d = mode_t'(wdata[1:0]);
			end else if (addr == OFS_CCC) begin
				ccc_d = wdata[2:0];
			end else if (addr == OFS_PERIOD) begin
				period_d = wdata;
			end else if (addr == OFS_DUTY) begin
				duty_d = wdata;
			end else if (addr == OFS_COUNT) begin
				count_d = count_q;
			end else if (addr == OFS_PRESC) begin
				presc_d = wdata[7:0];
			end else if (addr == OFS_OUTCTL) begin
				outctl_d = wdata[2:0];
			end else if (addr == OFS_STATUS) begin
				if (wdata[STAT_OVERFLOW]) begin
					ovf_d = 1'b0;
				end
			end
		end

		// A start from the stop state begins at zero with the output preset.
		if (!running && wr && addr == OFS_MODE && wdata[1:0] != 2'h0) begin
			count_d = RESET_ZERO;
			ff_d = outctl_q[OUT_PERIOD_INV];
		end

		// Counting and compare matches.
		if (tick) begin
			case (mode_q)
				MODE_CLEAR_MATCH: begin
					if (period_hit) begin
						count_d = RESET_ZERO; // R01 R03 R09
						pirq_d = 1'b1; // R01
						if (count_q == COUNT_MAX) begin
							ovf_d = 1'b1; // R04
						end
						if (outctl_q[OUT_PERIOD_INV]) begin
							ff_d = ~ff_d; // R07 R22 R25
						end
					end else begin
						count_d = count_q + 16'h0001;
					end
					if (duty_hit && !period_hit) begin
						dirq_d = 1'b1;
						if (outctl_q[OUT_DUTY_INV]) begin
							ff_d = ~ff_d; // R07 R22 R25
						end
					end
				end
				MODE_FREE_RUN, MODE_CLEAR_EDGE_A: begin
					count_d = count_q + 16'h0001; // R24
					if (count_q == COUNT_MAX) begin
						ovf_d = 1'b1; // R24
					end
				end
				default: count_d = count_q;
			endcase
		end

		// Captures in the measurement modes.
		if (mode_q == MODE_FREE_RUN || mode_q == MODE_CLEAR_EDGE_A) begin
			if (edge_a && ccc_q[CCC_DUTY_CAP]) begin
				duty_d = count_q; // R13 R14
				dirq_d = 1'b1; // R14
				if (mode_q == MODE_CLEAR_EDGE_A) begin
					count_d = RESET_ZERO; // R13
				end
			end
			if (ccc_q[CCC_PERIOD_CAP]) begin
				if (ccc_q[CCC_PERIOD_INV_A]) begin
					if (inv_edge_a) begin
						period_d = count_q;
					end
				end else if (edge_b) begin
					period_d = count_q; // R16
					pirq_d = 1'b1; // R16
				end
			end
		end

		// Stopping the timer clears the counter and the output flip-flop.
		if (mode_d == MODE_STOP) begin
			count_d = RESET_ZERO;
			ff_d = 1'b0;
		end

		pin_d = outctl_d[OUT_ENABLE] & ff_d; // R23

		// Read data for the cycle after the read strobe; cycles without a read give zero.
		if (rd) begin
			if (addr == OFS_MODE) begin
				rdata_d = {14'h0000, mode_q};
			end else if (addr == OFS_CCC) begin
				rdata_d = {13'h0000, ccc_q};
			end else if (addr == OFS_PERIOD) begin
				rdata_d = period_q;
			end else if (addr == OFS_DUTY) begin
				rdata_d = duty_q;
			end else if (addr == OFS_COUNT) begin
				rdata_d = count_q;
			end else if (addr == OFS_PRESC) begin
				rdata_d = {8'h00, presc_q};
			end else if (addr == OFS_OUTCTL) begin
				rdata_d = {13'h0000, outctl_q};
			end else if (addr == OFS_STATUS) begin
				rdata_d = {14'h0000, ff_q, ovf_q};
			end
		end
	end

	// Registers of the timer state and outputs.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_q <= MODE_STOP;
			ccc_q <= 3'h0;
			presc_q <= PRESC_RESET;
			outctl_q <= 3'h0;
			period_q <= RESET_ZERO;
			duty_q <= RESET_ZERO;
			count_q <= RESET_ZERO;
			div_q <= PRESC_RESET;
			ovf_q <= 1'b0;
			ff_q <= 1'b0;
			timer_output_pin <= 1'b0;
			period_match_irq <= 1'b0;
			duty_capture_irq <= 1'b0;
			rdata_q <= RESET_ZERO;
		end else begin
			mode_q <= mode_d;
			ccc_q <= ccc_d;
			presc_q <= presc_d;
			outctl_q <= outctl_d;
			period_q <= period_d;
			duty_q <= duty_d;
			count_q <= count_d;
			div_q <= div_d;
			ovf_q <= ovf_d;
			ff_q <= ff_d;
			timer_output_pin <= pin_d;
			period_match_irq <= pirq_d;
			duty_capture_irq <= dirq_d;
			rdata_q <= rdata_d;
		end
	end
endmodule
`default_nettype wire

// ---- timer_sva.sv ----
// Port assertions for the timer, bound into it below.
`timescale 1ns/1ps
`default_nettype none
module timer_sva
	import timer_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [timer_pkg::ADDR_W-1:0] addr,
	input wire logic [timer_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [timer_pkg::DATA_W-1:0] rdata_q,
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	input wire logic timer_output_pin,
	input wire logic period_match_irq,
	input wire logic duty_capture_irq
);
	logic [1:0] mode_q;
	logic [7:0] sel_q;
	logic [15:0] per_q;
	logic [15:0] duty_q;
	logic oe_q;
	logic ok_q;
	logic [16:0] gap_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// A read request at one offset.
	sequence s_read(logic [2:0] a);
		rd && addr == a;
	endsequence
	// Shadows of settings and cycles since the last period request.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_q <= 2'h0;
			sel_q <= 8'h00;
			per_q <= 16'h0000;
			duty_q <= 16'h0000;
			oe_q <= 1'b0;
			ok_q <= 1'b0;
			gap_q <= 17'h00000;
		end else begin
			if (wr && addr == OFS_MODE) mode_q <= wdata[1:0];
			if (wr && addr == OFS_PRESC) sel_q <= wdata[7:0];
			if (wr && addr == OFS_PERIOD) per_q <= wdata;
			if (wr && addr == OFS_DUTY) duty_q <= wdata;
			if (wr && addr == OFS_OUTCTL) oe_q <= wdata[0];
			ok_q <= !wr && (ok_q || period_match_irq);
			gap_q <= period_match_irq ? 17'h00001 : gap_q + {16'h0000, !gap_q[16]};
		end
	end
	a_read_idle_zero: assert property (!rd |=> rdata_q == 16'h0000)
		else $error("read data not zero");
	a_presc_read_bits: assert property (s_read(OFS_PRESC) |=> rdata_q == {8'h00, sel_q})
		else $error("prescaler read bits");
	a_mode_read_bits: assert property (s_read(OFS_MODE) |=> rdata_q == {14'h0000, mode_q})
		else $error("mode read bits");
	a_pin_disabled_low: assert property ((!oe_q) [*3] |-> !timer_output_pin)
		else $error("pin high while disabled");
	a_period_irq_pulse: assert property (period_match_irq |=> !period_match_irq)
		else $error("period request too long");
	a_duty_irq_pulse: assert property ($rose(duty_capture_irq) |=> $fell(duty_capture_irq))
		else $error("duty request too long");
	a_interval_gap: assert property (period_match_irq && ok_q && mode_q == 2'h2
		&& sel_q[1:0] == 2'h0 |-> gap_q == {1'b0, per_q} + 17'h00001)
		else $error("period spacing wrong");
	a_duty_gap: assert property (duty_capture_irq && ok_q && mode_q == 2'h2
		&& sel_q[1:0] == 2'h0 |-> gap_q == {1'b0, duty_q} + 17'h00001)
		else $error("duty spacing wrong");
endmodule
bind interval_ppg_pulse_timer timer_sva timer_sva_inst (.clk, .resetn, .addr, .wdata, .wr, .rd,
	.rdata_q, .timer_input_a, .timer_input_b, .timer_output_pin, .period_match_irq,
	.duty_capture_irq);
`default_nettype wire

// ---- pulse_src.sv ----
// Model of an external pulse source on one timer input pin.
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
	input wire logic clk,
	input wire logic en,
	input wire logic [15:0] hi_len,
	input wire logic [15:0] lo_len,
	output logic sig
);
	logic [15:0] cnt_q;
	logic lvl_q;
	// Alternates low and high phases of the given lengths; rests low when off.
	always_ff @(posedge clk) begin
		if (!en) begin
			cnt_q <= 16'h0000;
			lvl_q <= 1'b0;
		end else if (cnt_q + 16'h0001 >= (lvl_q ? hi_len : lo_len)) begin
			cnt_q <= 16'h0000;
			lvl_q <= !lvl_q;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	assign sig = en && lvl_q;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the interval, pulse and capture timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import timer_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en_a = 1'b0;
	logic en_b = 1'b0;
	logic [15:0] hi_a = 16'h0014;
	logic [15:0] rdata_q;
	logic timer_input_a, timer_input_b, timer_output_pin, period_match_irq, duty_capture_irq;
	int errors = 0;
	int checks = 0;
	always #5 clk = !clk;
	interval_ppg_pulse_timer interval_ppg_pulse_timer_inst (.clk, .resetn, .addr, .wdata, .wr,
		.rd, .rdata_q, .timer_input_a, .timer_input_b, .timer_output_pin, .period_match_irq,
		.duty_capture_irq);
	pulse_src pulse_src_inst (.clk, .en(en_a), .hi_len(hi_a), .lo_len(16'h0014),
		.sig(timer_input_a));
	pulse_src pulse_src_b_inst (.clk, .en(en_b), .hi_len(16'h001E), .lo_len(16'h001E),
		.sig(timer_input_b));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata_q;
	endtask
	// Counts cycles up to the chosen request; a hang ends the run.
	task automatic wait_irq(input logic sel, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (n > 2000) begin
				errors++;
				$display("ERROR %0t: timeout", $time);
				results();
			end
		end while ((sel ? duty_capture_irq : period_match_irq) !== 1'b1);
	endtask
	task automatic sample(input int cyc, input logic sel, output int n);
		n = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1 n += ((sel ? duty_capture_irq : timer_output_pin) === 1'b1);
		end
	endtask
	task automatic t_regs();
		logic [15:0] v;
		for (int i = 0; i < 8; i++) begin
			rreg(3'(i), v);
			check(v, 16'h0000);
		end
		wreg(OFS_COUNT, 16'h1234);
		wreg(OFS_MODE, 16'hFFFC);
		rreg(OFS_COUNT, v);
		check(v, 16'h0000);
	endtask
	task automatic t_interval(input logic [15:0] presc, input int mult);
		int n;
		logic [15:0] v;
		wreg(OFS_MODE, 16'h0000);
		wreg(OFS_CCC, 16'h0000);
		wreg(OFS_PERIOD, 16'h0004);
		wreg(OFS_PRESC, presc);
		wreg(OFS_MODE, 16'h0002);
		wait_irq(1'b0, n);
		wait_irq(1'b0, n);
		check(16'(n), 16'(5 * mult));
		rreg(OFS_STATUS, v);
		check(v, 16'h0000);
	endtask
	task automatic t_ppg();
		int n;
		wreg(OFS_MODE, 16'h0000);
		wreg(OFS_CCC, 16'h0000);
		wreg(OFS_PERIOD, 16'h0009);
		wreg(OFS_DUTY, 16'h0002);
		wreg(OFS_OUTCTL, 16'h0007);
		wreg(OFS_PRESC, 16'h0000);
		wreg(OFS_MODE, 16'h0002);
		wait_irq(1'b0, n);
		sample(10, 1'b0, n);
		check(16'(n), 16'h0003);
		wreg(OFS_OUTCTL, 16'h0005);
		sample(3, 1'b0, n);
		sample(20, 1'b0, n);
		check(16'(n), 16'h000A);
		wreg(OFS_OUTCTL, 16'h0001);
		sample(3, 1'b0, n);
		sample(20, 1'b0, n);
		check(16'(n % 20), 16'h0000);
		wreg(OFS_OUTCTL, 16'h0006);
		sample(3, 1'b0, n);
		sample(20, 1'b0, n);
		check(16'(n), 16'h0000);
		// Duty change while running: inversion off, new duty, one count clock, inversion on.
		wreg(OFS_OUTCTL, 16'h0002);
		wreg(OFS_DUTY, 16'h0005);
		@(posedge clk);
		wreg(OFS_OUTCTL, 16'h0006);
		wait_irq(1'b0, n);
		wait_irq(1'b1, n);
		check(16'(n), 16'h0006);
	endtask
	task automatic t_capture(input logic [15:0] ccc, input logic [15:0] presc, input logic sel,
		input logic [15:0] gap, input logic [15:0] mode);
		int n;
		logic [15:0] c0;
		logic [15:0] c1;
		wreg(OFS_MODE, 16'h0000);
		wreg(OFS_CCC, ccc);
		wreg(OFS_PRESC, presc);
		wreg(OFS_MODE, mode);
		en_a <= 1'b1;
		en_b <= 1'b1;
		// The first capture only aligns with the source; the next two are measured.
		wait_irq(sel, n);
		wait_irq(sel, n);
		rreg(sel ? OFS_DUTY : OFS_PERIOD, c0);
		wait_irq(sel, n);
		rreg(sel ? OFS_DUTY : OFS_PERIOD, c1);
		check(c1 - c0, gap);
		if (mode == 16'h0003) begin
			// Restart on each rising edge, so the falling edge captures the high time less one.
			rreg(OFS_PERIOD, c0);
			check(c0, 16'h0013);
		end
		en_a <= 1'b0;
		en_b <= 1'b0;
	endtask
	task automatic t_glitch();
		int n;
		wreg(OFS_MODE, 16'h0001);
		hi_a <= 16'h0001;
		en_a <= 1'b1;
		sample(100, 1'b1, n);
		check(16'(n), 16'h0000);
		en_a <= 1'b0;
	endtask
	task automatic t_overflow();
		logic [15:0] v;
		wreg(OFS_MODE, 16'h0000);
		wreg(OFS_OUTCTL, 16'h0000);
		wreg(OFS_MODE, 16'h0001);
		repeat (65540) @(posedge clk);
		rreg(OFS_STATUS, v);
		check(v, 16'h0001);
		wreg(OFS_STATUS, 16'h0001);
		rreg(OFS_STATUS, v);
		check(v, 16'h0000);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_interval(16'h0000, 1);
		t_interval(16'h0001, 4);
		t_interval(16'h0002, 256);
		en_a <= 1'b1;
		t_interval(16'h0013, 40);
		en_a <= 1'b0;
		t_ppg();
		t_capture(16'h0002, 16'h0030, 1'b1, 16'h0014, 16'h0001);
		t_capture(16'h0003, 16'h00F0, 1'b0, 16'h001E, 16'h0001);
		t_capture(16'h0007, 16'h0010, 1'b1, 16'h0000, 16'h0003);
		t_glitch();
		t_overflow();
		results();
	end
endmodule
`default_nettype wire
